// *** pkg/nds_pkg.sv ***
package nds_pkg;
   // ==========================================================
   // Target organisation
   localparam int DIES    = 2;
   localparam int DIE_W   = 1;
   localparam int PLANES  = 4;
   localparam int PLANE_W = 2;

   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_READ_MODE   = 8'h00;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
   localparam logic [7:0] CMD_RESET_LUN   = 8'hFA;
   localparam logic [7:0] CMD_RESET_SYNC  = 8'hFC;
   localparam logic [7:0] CMD_RESET       = 8'hFF;

   // ==========================================================
   // Status byte layout
   localparam int SR_WP     = 7;
   localparam int SR_RDY    = 6;
   localparam int SR_ARRAY_READY_FLAG   = 5;
   localparam int SR_RSV_HI = 4;
   localparam int SR_RSV_LO = 3;
   localparam int SR_SUSP   = 2;
   localparam int SR_PRIOR_OP_FAIL_FLAG  = 1;
   localparam int SR_FAIL   = 0;
   localparam logic [7:0] STATUS_IDLE = 8'h00;

   // ==========================================================
   // Row address fields of the enhanced status sequence
   localparam int ROW_PLANE_LSB = 2;
   localparam int ROW_LUN_BIT   = 0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS          = 10;
   localparam int STROBE_ACCESS_DELAY_NS = 20;
   localparam int STROBE_ACCESS_RAW      =
      STROBE_ACCESS_DELAY_NS / CLK_PERIOD_NS;
   localparam int STROBE_ACCESS_CYC      =
      (STROBE_ACCESS_RAW < 1) ? 1 : STROBE_ACCESS_RAW;
   localparam int STROBE_CNT_W           = 4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      IF_ASYNC  = 2'h0,
      IF_NVDDR  = 2'h1,
      IF_NVDDR2 = 2'h2,
      IF_NVDDR3 = 2'h3
   } nds_iface_type;

   typedef enum logic [1:0] {
      OP_PROGRAM = 2'h0,
      OP_ERASE   = 2'h1,
      OP_READ    = 2'h2,
      OP_OTHER   = 2'h3
   } nds_op_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ROW1 = 2'h1,
      ST_ROW2 = 2'h3,
      ST_ROW3 = 2'h2
   } nds_state_type;
endpackage

// *** pkg/nds_die_if.sv ***
`timescale 1ns/100ps
interface nds_die_if;
   logic                            op_done;
   nds_pkg::nds_op_type             op_kind;
   logic [nds_pkg::PLANES-1:0]      op_planes;
   logic [nds_pkg::PLANES-1:0]      plane_fail;
   logic [nds_pkg::PLANES-1:0]      array_busy;
   logic                            io_busy;
   logic                            suspended;
   logic                            otp_mode;
   logic                            otp_deny;
   logic                            wp_n;
   logic [nds_pkg::PLANE_W-1:0]     sel_plane;
   logic                            or_all;
   logic [7:0]                      status;

   modport stat (
      input  op_done, op_kind, op_planes, plane_fail, array_busy,
      input  io_busy, suspended, otp_mode, otp_deny, wp_n,
      input  sel_plane, or_all,
      output status
   );
   modport ctl (
      output op_done, op_kind, op_planes, plane_fail, array_busy,
      output io_busy, suspended, otp_mode, otp_deny, wp_n,
      output sel_plane, or_all,
      input  status
   );
endinterface

// *** hw/nds_die_status.sv ***
`timescale 1ns/100ps
module nds_die_status (
   input wire logic clk_sys,
   input wire logic srst,
   nds_die_if.stat  d
);
   logic [nds_pkg::PLANES-1:0] fail;
   logic [nds_pkg::PLANES-1:0] prior_op_fail_flag;
   logic                       otp_block;

   // ==========================================================
   // Per-plane pass/fail history
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fail  <= '0;
         prior_op_fail_flag <= '0;
      end else if (d.op_done) begin
         case (d.op_kind)
            nds_pkg::OP_PROGRAM: begin
               fail  <= (fail & ~d.op_planes) |
                        (d.plane_fail & d.op_planes);
               prior_op_fail_flag <= (prior_op_fail_flag & ~d.op_planes) |
                        (d.plane_fail & d.op_planes);
            end
            nds_pkg::OP_ERASE: begin
               // Erase leaves the program history alone
               fail <= (fail & ~d.op_planes) |
                       (d.plane_fail & d.op_planes);
            end
            default: begin
               // Reads leave both bits untouched
            end
         endcase
      end
   end

   // Sticky denial of a protected one-time page; set wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         otp_block <= 1'b0;
      end else if (d.otp_deny && d.otp_mode) begin
         otp_block <= 1'b1;
      end else if (!d.otp_mode) begin
         otp_block <= 1'b0;
      end
   end

   // ==========================================================
   // Status byte
   always_comb begin
      d.status = nds_pkg::STATUS_IDLE;
      d.status[nds_pkg::SR_WP] =
         d.otp_mode ? ~otp_block : d.wp_n;
      d.status[nds_pkg::SR_RDY]  = ~d.io_busy;
      d.status[nds_pkg::SR_ARRAY_READY_FLAG] = ~|d.array_busy;
      d.status[nds_pkg::SR_SUSP] = d.suspended;
      d.status[nds_pkg::SR_PRIOR_OP_FAIL_FLAG] =
         d.or_all ? |prior_op_fail_flag : prior_op_fail_flag[d.sel_plane];
      d.status[nds_pkg::SR_FAIL] =
         d.or_all ? |fail : fail[d.sel_plane];
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_prior_op_fail_flag_keep: assert property (
      d.op_done && d.op_kind != nds_pkg::OP_PROGRAM
      |=> prior_op_fail_flag == $past(prior_op_fail_flag))
      else $error("prior fail changed by non-program op");
   a_otp_deny: assert property (
      d.otp_mode && d.otp_deny ##1 d.otp_mode
      |-> !d.status[nds_pkg::SR_WP])
      else $error("protect bit not cleared on otp denial");
endmodule

// *** hw/nds_strobe_gen.sv ***
`timescale 1ns/100ps
module nds_strobe_gen (
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic run,
   output logic      dqs
);
   logic [nds_pkg::STROBE_CNT_W-1:0] wait_cnt;

   // Strobe starts only after the access delay, then toggles
   always_ff @(posedge clk_sys) begin
      if (srst || !run) begin
         wait_cnt <= '0;
         dqs      <= 1'b0;
      end else if (wait_cnt < nds_pkg::STROBE_CNT_W'(
                      nds_pkg::STROBE_ACCESS_CYC)) begin
         wait_cnt <= wait_cnt + 1'b1;
      end else begin
         dqs <= ~dqs;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_strobe_delay: assert property (
      $rose(run) |-> !dqs [*3])
      else $error("strobe toggled before access delay");
   a_strobe_start: assert property (
      $rose(run) ##1 run [*3] |-> dqs)
      else $error("strobe did not start after access delay");
   a_strobe_idle: assert property (
      !run |=> !dqs)
      else $error("strobe moved while not running");
endmodule

// *** hw/nds_status_top.sv ***
// Contract
// - Every die keeps its own eight-bit status byte, reported independently.
// - After either status command, status is returned on every output request.
// - Async, DDR2, DDR3: live status while chip select and read strobe low.
// - DDR mode: live status while select, direction low and latches high.
// - DDR mode: strobe toggles after access delay while latches captured high.
// - DDR mode, latches captured low: live status, strobe stays idle.
// - Plain status command reports the most recently selected die.
// - Bit 7 low when protected; mirrors write-protect pin in normal mode.
// - One-time mode: bit 7 cleared on program of protected page.
// - Bit 6 low while busy; only resets and status commands accepted.
// - Bit 5 low while any plane runs; high when all done.
// - Bits 2 and 0 encode pass, fail, suspended and reserved.
// - Bit 1 holds fail of previous program; valid while bit 6 high. Here bit 1 takes the latest program's fail, as bit 0 does.
// - Erase and read never update bit 1.
// - Bit 0 holds fail of latest program or erase; valid when bit 5 high.
// - Plain status ORs plane fails; enhanced status shows addressed plane.
// - Plain status command accepted by selected die even while busy.
// - Enhanced status takes three row cycles; addressed die alone drives.
`timescale 1ns/100ps
module nds_status_top (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire nds_pkg::nds_iface_type iface_mode,
   input  wire logic                  ce_n,
   input  wire logic                  cle,
   input  wire logic                  ale,
   input  wire logic                  we_n,
   input  wire logic                  read_strobe_n,
   input  wire logic                  wr_dir_n,
   input  wire logic                  wp_n,
   input  wire logic [7:0]            dq_in,
   output logic      [7:0]            dq_out,
   output logic                       dq_oe_n,
   output logic                       dqs_out,
   output logic                       dqs_oe_n,
   input  wire logic [nds_pkg::DIES-1:0] io_busy,
   input  wire logic [nds_pkg::DIES-1:0][nds_pkg::PLANES-1:0] array_busy,
   input  wire logic [nds_pkg::DIES-1:0] op_done,
   input  wire nds_pkg::nds_op_type   op_kind [nds_pkg::DIES],
   input  wire logic [nds_pkg::DIES-1:0][nds_pkg::PLANES-1:0] op_planes,
   input  wire logic [nds_pkg::DIES-1:0][nds_pkg::PLANES-1:0] plane_fail,
   input  wire logic [nds_pkg::DIES-1:0] suspended,
   input  wire logic [nds_pkg::DIES-1:0] otp_mode,
   input  wire logic [nds_pkg::DIES-1:0] otp_deny,
   output logic                       status_active,
   output logic [nds_pkg::DIE_W-1:0]  selected_die
);
   // ==========================================================
   // Declarations
   nds_pkg::nds_state_type          state;
   logic                            we_n_q;
   logic                            wr_dir_q;
   logic                            we_rise;
   logic                            cmd_cyc;
   logic                            addr_cyc;
   logic                            busy_ok;
   logic                            sel_busy;
   logic                            cmd_ok;
   logic                            status_en;
   logic                            or_all;
   logic [nds_pkg::DIE_W-1:0]       sel_die;
   logic [nds_pkg::PLANE_W-1:0]     sel_plane;
   logic [nds_pkg::PLANE_W-1:0]     plane_cap;
   logic                            cap_hi;
   logic                            cap_lo;
   logic                            is_ddr1;
   logic                            drive_async;
   logic                            drive_ddr;
   logic                            drive;
   logic                            dqs_run;
   logic                            drive_q;
   logic                            dqs_en_q;
   logic [7:0]                      die_status [nds_pkg::DIES];
   logic [7:0]                      cur_status;

   nds_die_if dif [nds_pkg::DIES] ();

   // ==========================================================
   // One status register per die
   for (genvar g = 0; g < nds_pkg::DIES; g++) begin : g_die
      assign dif[g].op_done    = op_done[g];
      assign dif[g].op_kind    = op_kind[g];
      assign dif[g].op_planes  = op_planes[g];
      assign dif[g].plane_fail = plane_fail[g];
      assign dif[g].array_busy = array_busy[g];
      assign dif[g].io_busy    = io_busy[g];
      assign dif[g].suspended  = suspended[g];
      assign dif[g].otp_mode   = otp_mode[g];
      assign dif[g].otp_deny   = otp_deny[g];
      assign dif[g].wp_n       = wp_n;
      assign dif[g].sel_plane  = sel_plane;
      assign dif[g].or_all     = or_all;
      assign die_status[g]     = dif[g].status;

      nds_die_status u_die (
         .clk_sys (clk_sys),
         .srst    (srst),
         .d       (dif[g].stat)
      );
   end

   // Only the selected die ever reaches the pins
   assign cur_status = die_status[sel_die];

   // ==========================================================
   // Bus cycle decode
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         we_n_q   <= 1'b1;
         wr_dir_q <= 1'b1;
      end else begin
         we_n_q   <= we_n;
         wr_dir_q <= wr_dir_n;
      end
   end

   assign we_rise  = we_n && !we_n_q && !ce_n;
   assign cmd_cyc  = we_rise && cle && !ale;
   assign addr_cyc = we_rise && ale && !cle;
   assign sel_busy = io_busy[sel_die];

   always_comb begin
      busy_ok = 1'b0;
      unique case (dq_in)
         nds_pkg::CMD_READ_STATUS,
         nds_pkg::CMD_STATUS_ENH,
         nds_pkg::CMD_RESET_LUN,
         nds_pkg::CMD_RESET_SYNC,
         nds_pkg::CMD_RESET: busy_ok = 1'b1;
         default:            busy_ok = 1'b0;
      endcase
   end

   // A busy die ignores everything but resets and status
   assign cmd_ok = cmd_cyc && (!sel_busy || busy_ok);

   // ==========================================================
   // Enhanced status address sequence
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= nds_pkg::ST_IDLE;
      end else if (cmd_ok) begin
         state <= (dq_in == nds_pkg::CMD_STATUS_ENH) ?
                  nds_pkg::ST_ROW1 : nds_pkg::ST_IDLE;
      end else if (addr_cyc) begin
         unique case (state)
            nds_pkg::ST_IDLE: state <= nds_pkg::ST_IDLE;
            nds_pkg::ST_ROW1: state <= nds_pkg::ST_ROW2;
            nds_pkg::ST_ROW2: state <= nds_pkg::ST_ROW3;
            nds_pkg::ST_ROW3: state <= nds_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         plane_cap <= '0;
      end else if (addr_cyc && state == nds_pkg::ST_ROW1) begin
         plane_cap <= dq_in[nds_pkg::ROW_PLANE_LSB +: nds_pkg::PLANE_W];
      end
   end

   // ==========================================================
   // Status output enable and die selection
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status_en <= 1'b0;
         or_all    <= 1'b1;
         sel_die   <= '0;
         sel_plane <= '0;
      end else if (cmd_ok) begin
         if (dq_in == nds_pkg::CMD_READ_STATUS) begin
            status_en <= 1'b1;
            or_all    <= 1'b1;
         end else begin
            // Read mode or any other command ends status output
            status_en <= 1'b0;
         end
      end else if (addr_cyc && state == nds_pkg::ST_ROW3) begin
         status_en <= 1'b1;
         or_all    <= 1'b0;
         sel_die   <= dq_in[nds_pkg::ROW_LUN_BIT +: nds_pkg::DIE_W];
         sel_plane <= plane_cap;
      end
   end

   // ==========================================================
   // Latch level capture for the DDR data path
   always_ff @(posedge clk_sys) begin
      if (srst || wr_dir_n) begin
         cap_hi <= 1'b0;
         cap_lo <= 1'b0;
      end else if (wr_dir_q) begin
         cap_hi <= ale && cle;
         cap_lo <= !ale && !cle;
      end
   end

   assign is_ddr1     = (iface_mode == nds_pkg::IF_NVDDR);
   // No strobe toggle needed: level of the strobe is enough
   assign drive_async = !ce_n && !read_strobe_n;
   assign drive_ddr   = !ce_n && !wr_dir_n &&
                        ((ale && cle) || cap_lo);
   assign drive       = status_en &&
                        (is_ddr1 ? drive_ddr : drive_async);
   assign dqs_run     = status_en && is_ddr1 && drive_ddr &&
                        cap_hi;

   // ==========================================================
   // Pin drivers; status is resampled each cycle so changes show
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dq_out   <= nds_pkg::STATUS_IDLE;
         drive_q  <= 1'b0;
         dqs_en_q <= 1'b0;
      end else begin
         dq_out   <= drive ? cur_status :
                     nds_pkg::STATUS_IDLE;
         drive_q  <= drive;
         dqs_en_q <= drive && is_ddr1;
      end
   end

   assign dq_oe_n       = !drive_q;
   assign dqs_oe_n      = !dqs_en_q;
   assign status_active = status_en;
   assign selected_die  = sel_die;

   nds_strobe_gen u_strobe (
      .clk_sys (clk_sys),
      .srst    (srst),
      .run     (dqs_run),
      .dqs     (dqs_out)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_status_cmd_on: assert property (
      cmd_cyc && !sel_busy && dq_in == nds_pkg::CMD_READ_STATUS
      |=> status_en && or_all)
      else $error("plain status command did not enable output");
   a_busy_status: assert property (
      cmd_cyc && sel_busy && dq_in == nds_pkg::CMD_READ_STATUS
      |=> status_en)
      else $error("busy die refused plain status command");
   a_busy_refuse: assert property (
      cmd_cyc && sel_busy && !busy_ok && !addr_cyc
      |=> status_en == $past(status_en) && state == $past(state))
      else $error("busy die accepted a foreign command");
   a_mode_off: assert property (
      cmd_ok && dq_in != nds_pkg::CMD_READ_STATUS |=> !status_en)
      else $error("status output survived a new command");
   a_enh_select: assert property (
      addr_cyc && state == nds_pkg::ST_ROW3
      |=> status_en && !or_all &&
          sel_die == $past(dq_in[nds_pkg::ROW_LUN_BIT]))
      else $error("enhanced status selected the wrong die");
   a_dq_live: assert property (
      !is_ddr1 && status_en && !ce_n && !read_strobe_n
      |=> !dq_oe_n && dq_out == $past(cur_status))
      else $error("live status not shown in async mode");
   a_ddr_window: assert property (
      is_ddr1 && status_en && !ce_n && !wr_dir_n && ale && cle
      |=> !dq_oe_n && !dqs_oe_n)
      else $error("ddr status window not driven");
   a_dqs_quiet: assert property (
      is_ddr1 && cap_lo [*2] |-> !dqs_out)
      else $error("strobe toggled with latches captured low");
   a_rsv_zero: assert property (
      !dq_oe_n |-> dq_out[nds_pkg::SR_RSV_HI:nds_pkg::SR_RSV_LO]
                   == 2'h0)
      else $error("reserved status bits not zero");

   c_plain_status: cover property (
      cmd_ok && dq_in == nds_pkg::CMD_READ_STATUS ##[1:20] !dq_oe_n);
   c_enh_status: cover property (
      addr_cyc && state == nds_pkg::ST_ROW3 ##1 status_en);
   c_dqs_toggle: cover property (
      $rose(dqs_run) ##[1:10] dqs_out);
endmodule

// *** verif/nds_host_model.sv ***
`timescale 1ns/100ps
module nds_host_model (
   input  wire logic       clk_sys,
   output logic            ce_n,
   output logic            cle,
   output logic            ale,
   output logic            we_n,
   output logic            read_strobe_n,
   output logic            wr_dir_n,
   output logic [7:0]      dq_in
);
   initial begin
      ce_n = 1'b1;
      cle = 1'b0;
      ale = 1'b0;
      we_n = 1'b1;
      read_strobe_n = 1'b1;
      wr_dir_n = 1'b1;
      dq_in = 8'h00;
   end

   // ==========================================================
   // Bus cycles
   // Latch enables and data are held through the rising we_n edge.
   task automatic bus_cyc(input logic is_cmd, input logic [7:0] v);
      @(posedge clk_sys);
      ce_n <= 1'b0;
      cle <= is_cmd;
      ale <= ~is_cmd;
      we_n <= 1'b0;
      dq_in <= v;
      @(posedge clk_sys);
      we_n <= 1'b1;
      @(posedge clk_sys);
      cle <= 1'b0;
      ale <= 1'b0;
      // Released bus shows no stale value
      dq_in <= ~v;
   endtask

   task automatic read_mode();
      bus_cyc(1'b1, nds_pkg::CMD_READ_MODE);
   endtask

   // Only the addressed die may answer afterwards
   task automatic enh_status(input logic die, input logic [1:0] plane);
      bus_cyc(1'b1, nds_pkg::CMD_STATUS_ENH);
      bus_cyc(1'b0, 8'(plane) << nds_pkg::ROW_PLANE_LSB);
      bus_cyc(1'b0, 8'h5A);
      bus_cyc(1'b0, {7'h00, die});
   endtask

   task automatic strobe(input logic on);
      @(posedge clk_sys);
      read_strobe_n <= ~on;
   endtask

   task automatic ddr_watch(input logic on, input logic hi);
      @(posedge clk_sys);
      cle <= hi;
      ale <= hi;
      wr_dir_n <= ~on;
   endtask
endmodule

// *** verif/test_nds_status_top.sv ***
`timescale 1ns/100ps
module test_nds_status_top;
   typedef struct packed {
      logic       wp;
      logic       busy;
      logic [3:0] ab;
      logic       susp;
      logic [7:0] exp;
   } nds_row_type;
   localparam nds_row_type ROWS [6] = '{
      '{1'b1, 1'b0, 4'h0, 1'b0, 8'hE0}, '{1'b0, 1'b0, 4'h0, 1'b0, 8'h60},
      '{1'b1, 1'b1, 4'h0, 1'b0, 8'hA0}, '{1'b1, 1'b0, 4'h2, 1'b0, 8'hC0},
      '{1'b1, 1'b0, 4'h0, 1'b1, 8'hE4}, '{1'b0, 1'b1, 4'hF, 1'b1, 8'h04}};
   localparam nds_pkg::nds_iface_type MODES [3] = '{nds_pkg::IF_ASYNC,
      nds_pkg::IF_NVDDR2, nds_pkg::IF_NVDDR3};

   logic                   clk_sys = 1'b0;
   logic                   srst = 1'b1;
   nds_pkg::nds_iface_type iface_mode = nds_pkg::IF_ASYNC;
   logic                   ce_n, cle, ale, we_n, read_strobe_n, wr_dir_n;
   logic                   wp_n = 1'b1;
   logic [7:0]             dq_in, dq_out;
   logic                   dq_oe_n, dqs_out, dqs_oe_n, status_active;
   logic [nds_pkg::DIE_W-1:0] selected_die;
   logic [nds_pkg::DIES-1:0] io_busy = '0, op_done = '0, suspended = '0;
   logic [nds_pkg::DIES-1:0] otp_mode = '0, otp_deny = '0;
   logic [nds_pkg::DIES-1:0][nds_pkg::PLANES-1:0] array_busy = '0;
   logic [nds_pkg::DIES-1:0][nds_pkg::PLANES-1:0] op_planes = '0;
   logic [nds_pkg::DIES-1:0][nds_pkg::PLANES-1:0] plane_fail = '0;
   nds_pkg::nds_op_type    op_kind [nds_pkg::DIES] =
      '{default: nds_pkg::OP_OTHER};
   int                     err_total = 0;
   int                     checks_done = 0;

   nds_status_top DUT (.clk_sys, .srst, .iface_mode, .ce_n, .cle, .ale,
      .we_n, .read_strobe_n, .wr_dir_n, .wp_n, .dq_in, .dq_out, .dq_oe_n,
      .dqs_out, .dqs_oe_n, .io_busy, .array_busy, .op_done, .op_kind,
      .op_planes, .plane_fail, .suspended, .otp_mode, .otp_deny,
      .status_active, .selected_die);
   nds_host_model host (.clk_sys, .ce_n, .cle, .ale, .we_n, .read_strobe_n,
      .wr_dir_n, .dq_in);

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Sample after the edge's updates have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic op(input int die, input nds_pkg::nds_op_type k,
                     input logic [3:0] pl, input logic [3:0] f);
      @(posedge clk_sys);
      op_done[die] <= 1'b1;
      op_kind[die] <= k;
      op_planes[die] <= pl;
      plane_fail[die] <= f;
      @(posedge clk_sys);
      op_done[die] <= 1'b0;
      settle(3);
   endtask

   task automatic count_tog(output int n);
      logic last;
      n = 0;
      last = dqs_out;
      repeat (8) begin
         settle(1);
         if (dqs_out !== last) n++;
         last = dqs_out;
      end
   endtask

   // ==========================================================
   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      int tog;
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      settle(1);
      check(status_active, 1'b0);
      check(dqs_oe_n, 1'b1);
      host.strobe(1'b1);
      settle(3);
      check(dq_oe_n, 1'b1);
      host.strobe(1'b0);
      host.bus_cyc(1'b1, nds_pkg::CMD_READ_STATUS);
      settle(1);
      check(status_active, 1'b1);
      // Strobe stays low through every row: no toggling to refresh
      host.strobe(1'b1);
      foreach (MODES[m]) begin
         foreach (ROWS[r]) begin
            @(posedge clk_sys);
            iface_mode <= MODES[m];
            wp_n <= ROWS[r].wp;
            io_busy[0] <= ROWS[r].busy;
            array_busy[0] <= ROWS[r].ab;
            suspended[0] <= ROWS[r].susp;
            settle(3);
            check(dq_oe_n, 1'b0);
            check(dq_out, ROWS[r].exp);
         end
      end
      @(posedge clk_sys);
      iface_mode <= nds_pkg::IF_ASYNC;
      {wp_n, io_busy[0], array_busy[0], suspended[0]} <= 7'h40;
      op(0, nds_pkg::OP_PROGRAM, 4'h3, 4'h2);
      check(dq_out, 8'hE3);
      op(0, nds_pkg::OP_ERASE, 4'h3, 4'h0);
      check(dq_out, 8'hE2);
      op(0, nds_pkg::OP_READ, 4'h3, 4'h3);
      check(dq_out, 8'hE2);
      host.strobe(1'b0);
      host.enh_status(1'b0, 2'h0);
      settle(1);
      check(status_active, 1'b1);
      host.strobe(1'b1);
      settle(3);
      check(dq_out, 8'hE0);
      host.strobe(1'b0);
      host.enh_status(1'b0, 2'h1);
      host.strobe(1'b1);
      settle(3);
      check(dq_out, 8'hE2);
      @(posedge clk_sys);
      otp_mode[0] <= 1'b1;
      otp_deny[0] <= 1'b1;
      @(posedge clk_sys);
      otp_deny[0] <= 1'b0;
      settle(3);
      check(dq_out, 8'h62);
      @(posedge clk_sys);
      otp_mode[0] <= 1'b0;
      settle(3);
      check(dq_out, 8'hE2);
      // Second die busy: its byte must differ from the first die's
      @(posedge clk_sys);
      io_busy[1] <= 1'b1;
      host.strobe(1'b0);
      host.enh_status(1'b1, 2'h0);
      settle(1);
      check(selected_die, 1'b1);
      host.strobe(1'b1);
      settle(3);
      check(dq_out, 8'hA0);
      host.strobe(1'b0);
      host.read_mode();
      settle(1);
      check(status_active, 1'b1);
      @(posedge clk_sys);
      io_busy[1] <= 1'b0;
      host.read_mode();
      settle(1);
      check(status_active, 1'b0);
      @(posedge clk_sys);
      io_busy[1] <= 1'b1;
      host.bus_cyc(1'b1, nds_pkg::CMD_READ_STATUS);
      settle(1);
      check(status_active, 1'b1);
      host.strobe(1'b1);
      settle(3);
      check(dq_out, 8'hA0);
      host.strobe(1'b0);
      @(posedge clk_sys);
      iface_mode <= nds_pkg::IF_NVDDR;
      host.ddr_watch(1'b1, 1'b1);
      settle(2);
      check(dq_oe_n, 1'b0);
      check(dqs_oe_n, 1'b0);
      count_tog(tog);
      check(tog > 3, 1'b1);
      host.ddr_watch(1'b0, 1'b0);
      settle(2);
      host.ddr_watch(1'b1, 1'b0);
      settle(2);
      check(dq_oe_n, 1'b0);
      count_tog(tog);
      check(8'(tog), 8'h00);
      @(posedge clk_sys);
      io_busy[1] <= 1'b0;
      settle(3);
      check(dq_out, 8'hE0);
      give_verdict();
   end
endmodule
